// >>> design/mrc_cycle_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Counts one measurement cycle of a given length and pulses at its end
module mrc_cycle_timer #(
    parameter int WIDTH = 24
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] length,
    output logic cycle_start
);
    logic [WIDTH-1:0] count;  // Cycles left in the current measurement
    logic [WIDTH-1:0] next_count;
    // Reload at zero; the length is only sampled at a reload
    always_comb begin
        cycle_start = (count == '0);
        next_count = cycle_start ? length - 1'b1 : count - 1'b1;
    end
    // Register the count
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : mrc_cycle_timer
`default_nettype wire

// >>> design/mrc_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "mrc_defs.svh"
// Turns a request into a legal rate or a rejection; purely combinational
module mrc_decode
    import mrc_pkg::*;
(
    input wire mrc_request_t req,
    output mrc_rate_t rate,
    output logic legal
);
    // Keyword path and speed alias path share one result
    always_comb begin
        rate = MRC_RATE_NORMAL;
        legal = 1'b0;
        if (req.kind == MRC_CMD_RATE_SET) begin
            legal = (req.keyword != MRC_KW_OTHER);
            case (req.keyword)
                MRC_KW_DOUBLE: rate = MRC_RATE_DOUBLE;
                MRC_KW_FAST: rate = MRC_RATE_FAST;
                default: rate = MRC_RATE_NORMAL;
            endcase
        end else if (req.kind == MRC_CMD_SPEED_SET) begin
            // 20 and 40 are exact; anything else from 1 to 400 means fast
            if (req.speed == `MRC_SPEED_NORMAL) begin
                legal = 1'b1;
            end else if (req.speed == `MRC_SPEED_DOUBLE) begin
                rate = MRC_RATE_DOUBLE;
                legal = 1'b1;
            end else if (req.speed != 16'h0000 && req.speed <= `MRC_SPEED_FAST_MAX) begin
                rate = MRC_RATE_FAST;
                legal = 1'b1;
            end
        end
    end
endmodule : mrc_decode
`default_nettype wire

// >>> design/mrc_defs.svh
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH
// Minimum acquisition times per reading, in microseconds
`define MRC_T_NORMAL_US 51200
`define MRC_T_DOUBLE_US 24576
`define MRC_T_FAST_US 2048
// Core clock rate in MHz
`define MRC_CLK_MHZ 200
// Cycle counts derived from the times; longest figure drives the counter width
`define MRC_CYC_NORMAL (`MRC_T_NORMAL_US * `MRC_CLK_MHZ)
`define MRC_CYC_DOUBLE (`MRC_T_DOUBLE_US * `MRC_CLK_MHZ)
`define MRC_CYC_FAST (`MRC_T_FAST_US * `MRC_CLK_MHZ)
// Speed alias values in readings per second
`define MRC_SPEED_NORMAL 16'h0014
`define MRC_SPEED_DOUBLE 16'h0028
`define MRC_SPEED_FAST_MAX 16'h0190
// Illegal parameter value error code (-224 as 16-bit two's complement)
`define MRC_ERR_ILLEGAL 16'hFF20
// Trigger count forced by the slow rates
`define MRC_TRIG_ONE 16'h0001
`endif

// >>> design/mrc_pkg.sv
package mrc_pkg;
    // Acquisition rate selection
    typedef enum logic [1:0] {
        MRC_RATE_NORMAL = 2'h0,
        MRC_RATE_DOUBLE = 2'h1,
        MRC_RATE_FAST = 2'h2
    } mrc_rate_t;
    // Command kinds from the command parser
    typedef enum logic [2:0] {
        MRC_CMD_NONE,
        MRC_CMD_RATE_SET,
        MRC_CMD_RATE_QUERY,
        MRC_CMD_SPEED_SET,
        MRC_CMD_SPEED_QUERY
    } mrc_cmd_t;
    // Rate keyword argument as decoded by the parser
    typedef enum logic [1:0] {
        MRC_KW_NORMAL = 2'h0,
        MRC_KW_DOUBLE = 2'h1,
        MRC_KW_FAST = 2'h2,
        MRC_KW_OTHER = 2'h3
    } mrc_kw_t;
    // Settings coupled to the fast rate
    typedef struct packed {
        logic averaging_enable;
        logic duty_cycle_correction_enable;
        logic secondary_gain_correction_enable;
        logic first_channel_term;  // Math formula reduced to the first channel alone
    } mrc_coupled_t;
    // One command from the host side
    typedef struct packed {
        mrc_cmd_t kind;
        mrc_kw_t keyword;
        logic [15:0] speed;
    } mrc_request_t;
    // Answer to a command
    typedef struct packed {
        logic is_error;
        logic [15:0] error_code;
        mrc_rate_t rate;
        logic [15:0] speed;
    } mrc_answer_t;
endpackage : mrc_pkg

// >>> design/mrc_rate_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "mrc_defs.svh"
module mrc_rate_control
    import mrc_pkg::*;
#(
    parameter int CYC_WIDTH = 24,
    parameter int CYC_NORMAL = `MRC_CYC_NORMAL,
    parameter int CYC_DOUBLE = `MRC_CYC_DOUBLE,
    parameter int CYC_FAST = `MRC_CYC_FAST
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire mrc_request_t req,
    input wire logic req_valid,
    input wire mrc_coupled_t user_settings,
    input wire logic [15:0] user_trigger_count,
    output mrc_answer_t answer,
    output logic answer_valid,
    output mrc_coupled_t active_settings,
    output logic [15:0] trigger_count,
    output logic trigger_count_load,
    output mrc_rate_t active_rate,
    output logic cycle_start
);
    // Refuse counts that do not fit or are empty
    initial begin
        if (CYC_NORMAL < 1 || CYC_DOUBLE < 1 || CYC_FAST < 1 ||
            CYC_NORMAL >= (1 << CYC_WIDTH) || CYC_DOUBLE >= (1 << CYC_WIDTH) ||
            CYC_FAST >= (1 << CYC_WIDTH)) begin
            $error("mrc_rate_control: cycle counts do not fit CYC_WIDTH");
        end
    end

    mrc_rate_t dec_rate;  // Rate asked for by the request
    logic dec_legal;  // Request carries a legal argument
    mrc_rate_t sel_rate;  // Selected rate as software sees it
    mrc_rate_t next_sel_rate;
    logic [15:0] sel_speed;  // Speed value last written, for the speed query
    logic [15:0] next_sel_speed;
    mrc_coupled_t saved;  // Settings captured when fast was entered
    mrc_coupled_t next_saved;
    mrc_coupled_t active;  // Settings the engine uses
    mrc_coupled_t next_active;
    logic in_fast;  // Coupling currently imposed
    logic next_in_fast;
    mrc_answer_t next_answer;
    logic next_answer_valid;
    logic [15:0] next_trigger_count;
    logic next_trigger_count_load;
    mrc_rate_t run_rate;  // Rate of the measurement cycle in progress
    mrc_rate_t next_run_rate;
    logic [CYC_WIDTH-1:0] cycle_len;  // Length for the next cycle
    logic set_ok;  // Legal set command this cycle
    logic set_bad;  // Illegal set command this cycle

    mrc_decode u_decode (
        .req(req),
        .rate(dec_rate),
        .legal(dec_legal)
    );

    // Cycle length follows the selection; the timer samples it only at reload
    always_comb begin
        case (sel_rate)
            MRC_RATE_DOUBLE: cycle_len = CYC_WIDTH'(CYC_DOUBLE);
            MRC_RATE_FAST: cycle_len = CYC_WIDTH'(CYC_FAST);
            default: cycle_len = CYC_WIDTH'(CYC_NORMAL);
        endcase
    end

    mrc_cycle_timer #(
        .WIDTH(CYC_WIDTH)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .length(cycle_len),
        .cycle_start(cycle_start)
    );

    // Command handling, coupling and restoration
    always_comb begin
        set_ok = req_valid && dec_legal &&
                 (req.kind == MRC_CMD_RATE_SET || req.kind == MRC_CMD_SPEED_SET);
        set_bad = req_valid && !dec_legal &&
                  (req.kind == MRC_CMD_RATE_SET || req.kind == MRC_CMD_SPEED_SET);
        next_sel_rate = sel_rate;
        next_sel_speed = sel_speed;
        next_saved = saved;
        next_in_fast = in_fast;
        next_trigger_count = trigger_count;
        next_trigger_count_load = 1'b0;
        next_answer = answer;
        next_answer_valid = 1'b0;
        next_run_rate = cycle_start ? sel_rate : run_rate;
        // Outside fast the user settings pass straight through
        next_active = in_fast ? active : user_settings;
        if (set_ok) begin
            next_sel_rate = dec_rate;
            case (dec_rate)
                MRC_RATE_NORMAL: next_sel_speed = `MRC_SPEED_NORMAL;
                MRC_RATE_DOUBLE: next_sel_speed = `MRC_SPEED_DOUBLE;
                default: next_sel_speed = (req.kind == MRC_CMD_SPEED_SET) ?
                                          req.speed : `MRC_SPEED_FAST_MAX;
            endcase
            if (dec_rate == MRC_RATE_FAST) begin
                if (!in_fast) begin
                    // Save what was in place, then impose the coupling
                    next_saved = user_settings;
                    next_in_fast = 1'b1;
                end
                next_active = '0;
                next_active.first_channel_term = 1'b1;
                // Trigger count is left to the host in fast mode
                next_trigger_count = user_trigger_count;
            end else begin
                if (in_fast) begin
                    next_active = saved;
                    next_in_fast = 1'b0;
                end
                next_trigger_count = `MRC_TRIG_ONE;
                next_trigger_count_load = 1'b1;
            end
            next_answer.is_error = 1'b0;
            next_answer.error_code = 16'h0000;
            next_answer.rate = dec_rate;
            next_answer.speed = next_sel_speed;
            next_answer_valid = 1'b1;
        end else if (set_bad) begin
            next_answer.is_error = 1'b1;
            next_answer.error_code = `MRC_ERR_ILLEGAL;
            next_answer_valid = 1'b1;
        end else if (req_valid && (req.kind == MRC_CMD_RATE_QUERY ||
                                   req.kind == MRC_CMD_SPEED_QUERY)) begin
            next_answer.is_error = 1'b0;
            next_answer.error_code = 16'h0000;
            next_answer.rate = sel_rate;
            next_answer.speed = sel_speed;
            next_answer_valid = 1'b1;
        end else begin
            // The host owns the count, fast mode included, except at a slow-rate set (forced to one) and at a query or illegal set (held)
            next_trigger_count = user_trigger_count;
        end
    end

    // Register command state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_rate <= MRC_RATE_NORMAL;
            sel_speed <= `MRC_SPEED_NORMAL;
            saved <= '0;
            active <= '0;
            in_fast <= 1'b0;
            answer <= '0;
            answer_valid <= 1'b0;
            trigger_count <= `MRC_TRIG_ONE;
            trigger_count_load <= 1'b0;
            run_rate <= MRC_RATE_NORMAL;
        end else begin
            sel_rate <= next_sel_rate;
            sel_speed <= next_sel_speed;
            saved <= next_saved;
            active <= next_active;
            in_fast <= next_in_fast;
            answer <= next_answer;
            answer_valid <= next_answer_valid;
            trigger_count <= next_trigger_count;
            trigger_count_load <= next_trigger_count_load;
            run_rate <= next_run_rate;
        end
    end

    // The engine sees the rate of the cycle it is running
    assign active_rate = run_rate;
    assign active_settings = active;
endmodule : mrc_rate_control
`default_nettype wire

// >>> dv/mrc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side: settings it would use and its trigger count habit
module mrc_host_model
    import mrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic shuffle,
    input wire mrc_rate_t active_rate,
    input wire mrc_answer_t answer,
    input wire logic answer_valid,
    output mrc_coupled_t user_settings,
    output logic [15:0] user_trigger_count,
    output logic calib_due
);
    // New settings only on request, so a saved copy stays predictable
    mrc_coupled_t set_q = 4'hF;
    logic [15:0] trig_q = 16'h0001;
    mrc_rate_t last_q = MRC_RATE_NORMAL;
    logic calib_q = 1'b0;
    assign user_settings = set_q;
    assign user_trigger_count = trig_q;
    assign calib_due = calib_q;
    always @(posedge core_clk) begin
        if (shuffle) begin
            set_q <= 4'($urandom);
        end
        // Buffered readings in fast mode shorten the delay; follow the confirmed
        // rate, since the running rate lags a change by up to a whole cycle
        if (answer_valid && !answer.is_error) begin
            trig_q <= (answer.rate == MRC_RATE_FAST) ? 16'h0004 : 16'h0001;
        end
        // Calibration owed after any rate change
        calib_q <= calib_q | (active_rate != last_q);
        last_q <= active_rate;
    end
endmodule : mrc_host_model
`default_nettype wire

// >>> dv/mrc_rate_control_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on answers, couplings and rate changes
module mrc_rate_control_sva
    import mrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire mrc_request_t req,
    input wire logic req_valid,
    input wire mrc_coupled_t user_settings,
    input wire logic [15:0] user_trigger_count,
    input wire mrc_answer_t answer,
    input wire logic answer_valid,
    input wire mrc_coupled_t active_settings,
    input wire logic [15:0] trigger_count,
    input wire logic trigger_count_load,
    input wire mrc_rate_t active_rate,
    input wire logic cycle_start
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A request that must be answered
    wire logic take = req_valid && req.kind != MRC_CMD_NONE;
    // A request that selects one of the slow rates
    wire logic slow = take && ((req.kind == MRC_CMD_RATE_SET && req.keyword inside
        {MRC_KW_NORMAL, MRC_KW_DOUBLE}) || (req.kind == MRC_CMD_SPEED_SET &&
        req.speed inside {16'h0014, 16'h0028}));
    chk_answer_latency: assert property (take |=> answer_valid)
        else $error("answer missing one cycle after request");
    chk_no_stray: assert property (!take |=> !answer_valid)
        else $error("answer without request");
    chk_bad_keyword: assert property (take && req.kind == MRC_CMD_RATE_SET &&
        req.keyword == MRC_KW_OTHER |=> answer.is_error && answer.error_code == 16'hFF20)
        else $error("bad rate keyword not refused");
    chk_bad_speed: assert property (take && req.kind == MRC_CMD_SPEED_SET &&
        (req.speed == 16'h0000 || req.speed > 16'h0190) |=> answer.is_error &&
        answer.error_code == 16'hFF20) else $error("bad speed not refused");
    chk_fast_couple: assert property (take && req.kind == MRC_CMD_RATE_SET &&
        req.keyword == MRC_KW_FAST |=> active_settings == 4'h1)
        else $error("fast couplings not applied");
    chk_slow_trigger: assert property (slow |=> trigger_count == 16'h0001 &&
        trigger_count_load) else $error("trigger count not forced to one");
    chk_speed_map: assert property (take && req.kind == MRC_CMD_SPEED_SET &&
        req.speed == 16'h0028 |=> !answer.is_error && answer.rate == MRC_RATE_DOUBLE)
        else $error("speed 40 not mapped to double rate");
    chk_rate_boundary: assert property ($changed(active_rate) && !$past(rst) |-> $past(cycle_start))
        else $error("rate changed outside a cycle start");
    chk_reset_state: assert property ($fell(rst) |-> active_rate == MRC_RATE_NORMAL &&
        trigger_count == 16'h0001) else $error("reset state wrong");
    cov_fast: cover property (take && req.kind == MRC_CMD_RATE_SET &&
        req.keyword == MRC_KW_FAST);
    cov_speed: cover property (take && req.kind == MRC_CMD_SPEED_SET);
    cov_load: cover property (trigger_count_load);
endmodule : mrc_rate_control_sva
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mrc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    mrc_request_t req = '0;
    logic req_valid = 1'b0;
    logic shuffle = 1'b0;
    mrc_coupled_t user_settings, active_settings, saved;
    logic [15:0] user_trigger_count, trigger_count, spd;
    mrc_answer_t answer;
    logic answer_valid, trigger_count_load, cycle_start;
    mrc_rate_t active_rate;
    mrc_answer_t exp_q[$]; // Expected answers in order
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    always #2.5 core_clk = ~core_clk;
    mrc_rate_control #(.CYC_NORMAL(50), .CYC_DOUBLE(24), .CYC_FAST(8)) mrc_rate_control_i (
        .core_clk(core_clk), .rst(rst), .req(req), .req_valid(req_valid),
        .user_settings(user_settings), .user_trigger_count(user_trigger_count),
        .answer(answer), .answer_valid(answer_valid), .active_settings(active_settings),
        .trigger_count(trigger_count), .trigger_count_load(trigger_count_load),
        .active_rate(active_rate), .cycle_start(cycle_start));
    mrc_host_model mrc_host_model_i (.core_clk(core_clk), .shuffle(shuffle),
        .active_rate(active_rate), .answer(answer), .answer_valid(answer_valid),
        .user_settings(user_settings),
        .user_trigger_count(user_trigger_count), .calib_due());
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (e !== g) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Errors carry only flag and code; other answers carry rate and speed
    task cmp_ans(input mrc_answer_t e, input mrc_answer_t g);
        chk("is_error", 16'(e.is_error), 16'(g.is_error));
        if (e.is_error) chk("error_code", e.error_code, g.error_code);
        else begin
            chk("rate", 16'(e.rate), 16'(g.rate));
            chk("speed", e.speed, g.speed);
        end
    endtask : cmp_ans
    task send(input mrc_cmd_t k, input mrc_kw_t w, input logic [15:0] s, input mrc_rate_t r,
        input logic [15:0] es, input logic bad);
        @(posedge core_clk);
        req <= '{k, w, s};
        req_valid <= 1'b1;
        exp_q.push_back('{bad, bad ? 16'hFF20 : 16'h0000, r, es});
    endtask : send
    task idle();
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : idle
    // Cycles until the next cycle start
    task wait_start(output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (cycle_start !== 1'b1 && k < 200);
    endtask : wait_start
    task conclude();
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Answers are matched in arrival order
    always @(negedge core_clk) begin
        if (answer_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("stray answer", 16'h0000, 16'h0001);
            else cmp_ans(exp_q.pop_front(), answer);
        end
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(96));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        send(MRC_CMD_RATE_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 0);
        send(MRC_CMD_SPEED_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 0);
        send(MRC_CMD_RATE_SET, MRC_KW_OTHER, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 1);
        send(MRC_CMD_SPEED_SET, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 1);
        spd = 16'h0191 + 16'($urandom_range(0, 99));
        send(MRC_CMD_SPEED_SET, MRC_KW_NORMAL, spd, MRC_RATE_NORMAL, 16'h0014, 1);
        idle();
        wait_start(n);
        wait_start(n);
        chk("normal cycle", 16'd50, 16'(n));
        shuffle <= 1'b1;
        @(posedge core_clk);
        shuffle <= 1'b0;
        repeat (2) @(posedge core_clk);
        saved = user_settings;
        send(MRC_CMD_RATE_SET, MRC_KW_FAST, 16'h0000, MRC_RATE_FAST, 16'h0190, 0);
        idle();
        chk("fast settings", 16'h0001, 16'(active_settings));
        spd = 16'($urandom_range(41, 399));
        send(MRC_CMD_SPEED_SET, MRC_KW_NORMAL, spd, MRC_RATE_FAST, spd, 0);
        send(MRC_CMD_SPEED_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_FAST, spd, 0);
        send(MRC_CMD_RATE_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_FAST, spd, 0);
        idle();
        wait_start(n);
        wait_start(n);
        wait_start(n);
        chk("fast cycle", 16'd8, 16'(n));
        chk("fast trigger count", 16'h0004, trigger_count);
        send(MRC_CMD_SPEED_SET, MRC_KW_NORMAL, 16'h0028, MRC_RATE_DOUBLE, 16'h0028, 0);
        send(MRC_CMD_RATE_SET, MRC_KW_DOUBLE, 16'h0000, MRC_RATE_DOUBLE, 16'h0028, 0);
        send(MRC_CMD_RATE_SET, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 0);
        idle();
        chk("restored", 16'(saved), 16'(active_settings));
        chk("trigger count", 16'h0001, trigger_count);
        send(MRC_CMD_RATE_SET, MRC_KW_FAST, 16'h0000, MRC_RATE_FAST, 16'h0190, 0);
        idle();
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        send(MRC_CMD_RATE_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 0);
        send(MRC_CMD_SPEED_QUERY, MRC_KW_NORMAL, 16'h0000, MRC_RATE_NORMAL, 16'h0014, 0);
        idle();
        chk("pending answers", 16'h0000, 16'(exp_q.size()));
        conclude();
    end
endmodule : tb
bind mrc_rate_control mrc_rate_control_sva mrc_rate_control_sva_i (.core_clk(core_clk),
    .rst(rst), .req(req), .req_valid(req_valid), .user_settings(user_settings),
    .user_trigger_count(user_trigger_count), .answer(answer), .answer_valid(answer_valid),
    .active_settings(active_settings), .trigger_count(trigger_count),
    .trigger_count_load(trigger_count_load), .active_rate(active_rate),
    .cycle_start(cycle_start));
`default_nettype wire
